// file: rtl/fault_seq_pkg.sv
`default_nettype none

package fault_seq_pkg;

  // ---------------------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] EVENT_ADDR  = 8'h08;
  localparam logic [7:0] MASK_ADDR   = 8'h0c;

  // CTRL fields
  localparam int CTRL_TURN_ON_BIT = 0;
  localparam int CTRL_BURST_BIT   = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // EVENT / MASK bit positions
  localparam int EV_IN_LOW   = 0;
  localparam int EV_IN_HIGH  = 1;
  localparam int EV_OUT_LOW  = 2;
  localparam int EV_TEMP     = 3;
  localparam int EV_OUT_HIGH = 4;
  localparam int EV_WIDTH    = 5;
  localparam logic [EV_WIDTH-1:0] MASK_RESET = 5'h00;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------------------
  // Timing (microseconds) and clock rate
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ            = 20_000_000;
  localparam int FAULT_WAIT_US     = 1000;
  localparam int INIT_US           = 100;
  localparam int TURN_ON_US        = 100;
  localparam int IN_LOW_QUAL_US    = 10;
  localparam int IN_HIGH_QUAL_US   = 10;
  localparam int FAULT_WAIT_CYC    = FAULT_WAIT_US * (CLK_HZ / 1_000_000);
  localparam int INIT_CYC          = INIT_US * (CLK_HZ / 1_000_000);
  localparam int TURN_ON_CYC       = TURN_ON_US * (CLK_HZ / 1_000_000);
  localparam int IN_LOW_QUAL_CYC   = IN_LOW_QUAL_US * (CLK_HZ / 1_000_000);
  localparam int IN_HIGH_QUAL_CYC  = IN_HIGH_QUAL_US * (CLK_HZ / 1_000_000);
  localparam int CNT_W             = 24;

  typedef enum {
    ST_POWER_UP,
    ST_INIT,
    ST_IDLE,
    ST_TURN_ON,
    ST_RUN,
    ST_FAULT_WAIT,
    ST_RECOVER
  } seq_state_t;

  typedef struct packed {
    logic in_above_low_rise;
    logic in_below_low_fall;
    logic in_above_high_rise;
    logic in_below_high_fall;
    logic in_below_init;
    logic fast_in_high;
    logic out_below_low;
    logic out_above_high;
    logic temp_over;
    logic low_energy;
    logic cycle_tick;
  } sense_t;

endpackage

`default_nettype wire

// file: rtl/converter_fault_sequencer.sv
// Behaviour
// - Before running, ignore turn-on until input passes rising low level.
// - Running input below falling low level: input-low fault, stop switching.
// - Input-low dips shorter than the qualify window cause no fault.
// - After input-low fault, await rising level, restart if turned on.
// - Input above rising high level: input-high fault, halt switching.
// - After input-high fault, await falling level, resume if turned on.
// - Fast input-high flag stops switching; resumes if cleared unqualified.
// - Input-high outlasting its window registers even when not switching.
// - Output below low threshold while switching: short fault, stop at once.
// - After output-low fault, wait fault time, then init and turn-on delays.
// - Over-temperature registers fault, stops at once, waits fault time.
// - Temperature recovery also waits for cooling, then init and turn-on.
// - Output over threshold, checked each switching cycle, disables stage.
// - Output-high fault is latched; no automatic restart while latched.
// - Latch clears only on turn-on pin removal or input below init level.
// - Under light load the stage is gated off and on in bursts.
// - Trim mode captured at first power-up is kept across faults, disables.
`timescale 1ns/1ns
`default_nettype none

module converter_fault_sequencer #(
  parameter int FAULT_WAIT_CYC   = fault_seq_pkg::FAULT_WAIT_CYC,
  parameter int INIT_CYC         = fault_seq_pkg::INIT_CYC,
  parameter int TURN_ON_CYC      = fault_seq_pkg::TURN_ON_CYC,
  parameter int IN_LOW_QUAL_CYC  = fault_seq_pkg::IN_LOW_QUAL_CYC,
  parameter int IN_HIGH_QUAL_CYC = fault_seq_pkg::IN_HIGH_QUAL_CYC
) (
  // Clock and reset
  input  wire  logic                 CLOCK_IN,
  input  wire  logic                 ARST_N_IN,
  // Sense flags from comparators
  input  wire  fault_seq_pkg::sense_t SENSE_IN,
  input  wire  logic                 TURN_ON_PIN_IN,
  input  wire  logic                 TRIM_PIN_LOW_IN,
  // Power stage
  output logic                       RUN_OUT,
  output logic                       TRIM_ACTIVE_OUT,
  output logic                       IRQ_OUT,
  // AXI4-Lite write address
  input  wire  logic                 AWVALID_IN,
  output logic                       AWREADY_OUT,
  input  wire  logic [7:0]           AWADDR_IN,
  // AXI4-Lite write data
  input  wire  logic                 WVALID_IN,
  output logic                       WREADY_OUT,
  input  wire  logic [31:0]          WDATA_IN,
  input  wire  logic [3:0]           WSTRB_IN,
  // AXI4-Lite write response
  output logic                       BVALID_OUT,
  input  wire  logic                 BREADY_IN,
  output logic [1:0]                 BRESP_OUT,
  // AXI4-Lite read address
  input  wire  logic                 ARVALID_IN,
  output logic                       ARREADY_OUT,
  input  wire  logic [7:0]           ARADDR_IN,
  // AXI4-Lite read data
  output logic                       RVALID_OUT,
  input  wire  logic                 RREADY_IN,
  output logic [31:0]                RDATA_OUT,
  output logic [1:0]                 RRESP_OUT
);

  // ---------------------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------------------
  // A count below one would wrap its terminal value to all ones
  if (FAULT_WAIT_CYC < 1 || INIT_CYC < 1 || TURN_ON_CYC < 1 ||
      IN_LOW_QUAL_CYC < 1 || IN_HIGH_QUAL_CYC < 1) begin
    $error("converter_fault_sequencer: counts below one");
  end
  // Every terminal value must fit the shared counter width
  if (FAULT_WAIT_CYC > (1 << fault_seq_pkg::CNT_W) ||
      INIT_CYC > (1 << fault_seq_pkg::CNT_W) ||
      TURN_ON_CYC > (1 << fault_seq_pkg::CNT_W) ||
      IN_LOW_QUAL_CYC > (1 << fault_seq_pkg::CNT_W) ||
      IN_HIGH_QUAL_CYC > (1 << fault_seq_pkg::CNT_W)) begin
    $error("converter_fault_sequencer: counts exceed counter width");
  end

  localparam int EW = fault_seq_pkg::EV_WIDTH;
  localparam int CW = fault_seq_pkg::CNT_W;
  localparam logic [CW-1:0] FW_T = CW'(FAULT_WAIT_CYC - 1);
  localparam logic [CW-1:0] IN_T = CW'(INIT_CYC - 1);
  localparam logic [CW-1:0] TO_T = CW'(TURN_ON_CYC - 1);
  localparam logic [CW-1:0] LQ_T = CW'(IN_LOW_QUAL_CYC - 1);
  localparam logic [CW-1:0] HQ_T = CW'(IN_HIGH_QUAL_CYC - 1);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    fault_seq_pkg::seq_state_t st;
    logic [CW-1:0]   cnt;
    logic [CW-1:0]   low_q;
    logic [CW-1:0]   high_q;
    logic            f_in_low;
    logic            f_in_high;
    logic            f_out_low;
    logic            f_temp;
    logic            ovp_latch;
    logic            trim_captured;
    logic            trim_active;
    logic            burst_on;
    logic            gate;
    logic [31:0]     ctrl;
    logic [EW-1:0]   events;
    logic [EW-1:0]   mask;
    logic            aw_full;
    logic [7:0]      aw_addr;
    logic            w_full;
    logic [31:0]     w_data;
    logic [3:0]      w_strb;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
  } state_t;

  state_t r;
  state_t next_r;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == fault_seq_pkg::CTRL_ADDR)   ||
             (a == fault_seq_pkg::STATUS_ADDR) ||
             (a == fault_seq_pkg::EVENT_ADDR)  ||
             (a == fault_seq_pkg::MASK_ADDR);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        m[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    merge = m;
  endfunction

  logic turn_on;
  logic any_fault;
  logic [EW-1:0] ev_set;
  logic [31:0] status_word;

  assign turn_on   = TURN_ON_PIN_IN && r.ctrl[fault_seq_pkg::CTRL_TURN_ON_BIT];
  assign any_fault = r.f_in_low || r.f_in_high || r.f_out_low ||
                     r.f_temp || r.ovp_latch;

  assign status_word = {21'h0, r.trim_active, r.gate, 4'(r.st),
                        r.ovp_latch, r.f_temp, r.f_out_low, r.f_in_high,
                        r.f_in_low};

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [31:0] wd;
    wd     = 32'h0;
    next_r = r;
    ev_set = '0;

    // Qualification counters for input lockouts
    if (SENSE_IN.in_below_low_fall) begin
      if (r.low_q != LQ_T) next_r.low_q = r.low_q + 1'b1;
    end else begin
      next_r.low_q = '0;
    end
    if (SENSE_IN.in_above_high_rise) begin
      if (r.high_q != HQ_T) next_r.high_q = r.high_q + 1'b1;
    end else begin
      next_r.high_q = '0;
    end

    // Input-low qualified only while running
    if (r.st == fault_seq_pkg::ST_RUN && SENSE_IN.in_below_low_fall &&
        r.low_q == LQ_T && !r.f_in_low) begin
      next_r.f_in_low = 1'b1;
      ev_set[fault_seq_pkg::EV_IN_LOW] = 1'b1;
    end
    if (r.f_in_low && SENSE_IN.in_above_low_rise) begin
      next_r.f_in_low = 1'b0;
    end

    // Input-high registered whether or not switching
    if (SENSE_IN.in_above_high_rise && r.high_q == HQ_T && !r.f_in_high) begin
      next_r.f_in_high = 1'b1;
      ev_set[fault_seq_pkg::EV_IN_HIGH] = 1'b1;
    end
    if (r.f_in_high && SENSE_IN.in_below_high_fall) begin
      next_r.f_in_high = 1'b0;
    end

    // Output overvoltage sampled once per switching cycle
    // A trip in the same cycle as a clear keeps the latch set
    if (RUN_OUT && SENSE_IN.cycle_tick && SENSE_IN.out_above_high) begin
      next_r.ovp_latch = 1'b1;
      ev_set[fault_seq_pkg::EV_OUT_HIGH] = 1'b1;
    end else if (r.ovp_latch &&
                 (!TURN_ON_PIN_IN || SENSE_IN.in_below_init)) begin
      next_r.ovp_latch = 1'b0;
    end

    // Trim mode caught once after the first init interval
    if (r.st == fault_seq_pkg::ST_INIT && r.cnt == IN_T &&
        !r.trim_captured) begin
      next_r.trim_captured = 1'b1;
      next_r.trim_active   = TRIM_PIN_LOW_IN;
    end

    // Light-load burst gating: toggle on each switching cycle
    if (r.st == fault_seq_pkg::ST_RUN && SENSE_IN.low_energy &&
        r.ctrl[fault_seq_pkg::CTRL_BURST_BIT]) begin
      next_r.burst_on = 1'b1;
      if (SENSE_IN.cycle_tick) next_r.gate = ~r.gate;
    end else begin
      next_r.burst_on = 1'b0;
      next_r.gate     = 1'b0;
    end

    // Sequencer
    next_r.cnt = r.cnt + 1'b1;
    case (r.st)
      fault_seq_pkg::ST_POWER_UP: begin
        next_r.cnt = '0;
        next_r.st  = fault_seq_pkg::ST_INIT;
      end
      fault_seq_pkg::ST_INIT: begin
        if (r.cnt == IN_T) begin
          next_r.cnt = '0;
          next_r.st  = fault_seq_pkg::ST_IDLE;
        end
      end
      fault_seq_pkg::ST_IDLE: begin
        next_r.cnt = '0;
        if (turn_on && SENSE_IN.in_above_low_rise && !any_fault) begin
          next_r.st = fault_seq_pkg::ST_TURN_ON;
        end
      end
      fault_seq_pkg::ST_TURN_ON: begin
        // A sagging input during the delay cancels the start
        if (!turn_on || any_fault || !SENSE_IN.in_above_low_rise) begin
          next_r.st  = fault_seq_pkg::ST_IDLE;
        end else if (r.cnt == TO_T) begin
          next_r.cnt = '0;
          next_r.st  = fault_seq_pkg::ST_RUN;
        end
      end
      fault_seq_pkg::ST_RUN: begin
        next_r.cnt = '0;
        if (SENSE_IN.out_below_low && !SENSE_IN.fast_in_high) begin
          next_r.f_out_low = 1'b1;
          ev_set[fault_seq_pkg::EV_OUT_LOW] = 1'b1;
          next_r.st = fault_seq_pkg::ST_FAULT_WAIT;
        end else if (SENSE_IN.temp_over) begin
          next_r.f_temp = 1'b1;
          ev_set[fault_seq_pkg::EV_TEMP] = 1'b1;
          next_r.st = fault_seq_pkg::ST_FAULT_WAIT;
        end else if (!turn_on || next_r.f_in_low || next_r.f_in_high ||
                     next_r.ovp_latch) begin
          next_r.st = fault_seq_pkg::ST_IDLE;
        end
      end
      fault_seq_pkg::ST_FAULT_WAIT: begin
        if (r.cnt >= FW_T && !(r.f_temp && SENSE_IN.temp_over)) begin
          next_r.f_out_low = 1'b0;
          next_r.f_temp    = 1'b0;
          next_r.cnt       = '0;
          next_r.st        = fault_seq_pkg::ST_RECOVER;
        end else if (r.cnt >= FW_T) begin
          // Park at the terminal count until the die has cooled
          next_r.cnt = FW_T;
        end
      end
      fault_seq_pkg::ST_RECOVER: begin
        if (r.cnt == IN_T) begin
          next_r.cnt = '0;
          next_r.st  = fault_seq_pkg::ST_IDLE;
        end
      end
      default: begin
        next_r.st  = fault_seq_pkg::ST_IDLE;
        next_r.cnt = '0;
      end
    endcase

    // ----------------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------------
    if (AWVALID_IN && AWREADY_OUT) begin
      next_r.aw_full = 1'b1;
      next_r.aw_addr = AWADDR_IN;
    end
    if (WVALID_IN && WREADY_OUT) begin
      next_r.w_full = 1'b1;
      next_r.w_data = WDATA_IN;
      next_r.w_strb = WSTRB_IN;
    end
    if (r.bvalid && BREADY_IN) next_r.bvalid = 1'b0;
    if (r.aw_full && r.w_full && !r.bvalid) begin
      next_r.aw_full = 1'b0;
      next_r.w_full  = 1'b0;
      next_r.bvalid  = 1'b1;
      next_r.bresp   = mapped(r.aw_addr) ? fault_seq_pkg::RESP_OKAY
                                         : fault_seq_pkg::RESP_SLVERR;
      wd = merge(32'h0, r.w_data, r.w_strb);
      case (r.aw_addr)
        fault_seq_pkg::CTRL_ADDR:
          next_r.ctrl = merge(r.ctrl, r.w_data, r.w_strb);
        fault_seq_pkg::EVENT_ADDR:
          next_r.events = r.events & ~wd[EW-1:0];
        fault_seq_pkg::MASK_ADDR:
          next_r.mask = wd[EW-1:0] | (r.mask & ~{EW{r.w_strb[0]}});
        default: begin
        end
      endcase
    end
    // Set beats write-one-to-clear in the same cycle
    next_r.events = next_r.events | ev_set;

    if (r.rvalid && RREADY_IN) next_r.rvalid = 1'b0;
    if (ARVALID_IN && ARREADY_OUT) begin
      next_r.rvalid = 1'b1;
      next_r.rresp  = mapped(ARADDR_IN) ? fault_seq_pkg::RESP_OKAY
                                        : fault_seq_pkg::RESP_SLVERR;
      case (ARADDR_IN)
        fault_seq_pkg::CTRL_ADDR:   next_r.rdata = r.ctrl;
        fault_seq_pkg::STATUS_ADDR: next_r.rdata = status_word;
        fault_seq_pkg::EVENT_ADDR:  next_r.rdata = 32'(r.events);
        fault_seq_pkg::MASK_ADDR:   next_r.rdata = 32'(r.mask);
        default:                    next_r.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      r      <= '0;
      r.st   <= fault_seq_pkg::ST_POWER_UP;
      r.ctrl <= fault_seq_pkg::CTRL_RESET;
      r.mask <= fault_seq_pkg::MASK_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  // Fast controller flag gates switching combinationally, no fault recorded
  assign RUN_OUT = (r.st == fault_seq_pkg::ST_RUN) && turn_on &&
                   !any_fault && !r.gate &&
                   !SENSE_IN.fast_in_high;
  assign TRIM_ACTIVE_OUT = r.trim_active;
  assign IRQ_OUT     = |(r.events & r.mask);
  assign AWREADY_OUT = !r.aw_full;
  assign WREADY_OUT  = !r.w_full;
  assign BVALID_OUT  = r.bvalid;
  assign BRESP_OUT   = r.bresp;
  assign ARREADY_OUT = !r.rvalid;
  assign RVALID_OUT  = r.rvalid;
  assign RDATA_OUT   = r.rdata;
  assign RRESP_OUT   = r.rresp;

endmodule

`default_nettype wire

// file: sim/fault_seq_checker.sv
`timescale 1ns/1ns
`default_nettype none

module fault_seq_checker (
  // Clock and reset
  input wire logic                  CLOCK_IN,
  input wire logic                  ARST_N_IN,
  // Supervision
  input wire fault_seq_pkg::sense_t SENSE_IN,
  input wire logic                  TURN_ON_PIN_IN,
  input wire logic                  RUN_OUT,
  // Bus
  input wire logic                  AWVALID_IN,
  input wire logic                  AWREADY_OUT,
  input wire logic                  WVALID_IN,
  input wire logic                  WREADY_OUT,
  input wire logic                  BVALID_OUT,
  input wire logic                  ARVALID_IN,
  input wire logic                  ARREADY_OUT,
  input wire logic                  RVALID_OUT
);
  // --------------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------------
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!ARST_N_IN);

  sequence ovp_trip;
    SENSE_IN.out_above_high && SENSE_IN.cycle_tick && RUN_OUT;
  endsequence

  // Pin stays on and input stays present, so nothing may clear the latch
  sequence latch_kept;
    (TURN_ON_PIN_IN && !SENSE_IN.in_below_init)[*8];
  endsequence

  fast_stop_a: assert property (SENSE_IN.fast_in_high |-> !RUN_OUT)
    else $error("run active during fast input-high flag");
  pin_off_a: assert property (!TURN_ON_PIN_IN |-> !RUN_OUT)
    else $error("run active with turn-on pin low");
  low_start_a: assert property (!SENSE_IN.in_above_low_rise &&
    !SENSE_IN.low_energy && !SENSE_IN.fast_in_high && !RUN_OUT |=> !RUN_OUT)
    else $error("started while input below rising low level");
  short_stop_a: assert property (SENSE_IN.out_below_low && RUN_OUT
    |-> ##[1:2] !RUN_OUT)
    else $error("run kept after output-low flag");
  temp_stop_a: assert property (SENSE_IN.temp_over && RUN_OUT
    |-> ##[1:2] !RUN_OUT)
    else $error("run kept after over-temperature flag");
  ovp_stop_a: assert property (ovp_trip |-> ##[1:2] !RUN_OUT)
    else $error("run kept after output-high trip");
  latch_hold_a: assert property (ovp_trip ##1 latch_kept |-> !RUN_OUT)
    else $error("restarted while output-high latch set");
  wr_answer_a: assert property (AWVALID_IN && AWREADY_OUT && WVALID_IN &&
    WREADY_OUT |-> ##[1:2] BVALID_OUT)
    else $error("write response missing");
  rd_answer_a: assert property (ARVALID_IN && ARREADY_OUT |=> RVALID_OUT)
    else $error("read data missing");
endmodule

bind converter_fault_sequencer fault_seq_checker chk (
  .CLOCK_IN(CLOCK_IN), .ARST_N_IN(ARST_N_IN), .SENSE_IN(SENSE_IN),
  .TURN_ON_PIN_IN(TURN_ON_PIN_IN), .RUN_OUT(RUN_OUT),
  .AWVALID_IN(AWVALID_IN), .AWREADY_OUT(AWREADY_OUT),
  .WVALID_IN(WVALID_IN), .WREADY_OUT(WREADY_OUT), .BVALID_OUT(BVALID_OUT),
  .ARVALID_IN(ARVALID_IN), .ARREADY_OUT(ARREADY_OUT),
  .RVALID_OUT(RVALID_OUT)
);

`default_nettype wire

// file: sim/turn_on_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none

module turn_on_ctrl_model #(
  parameter int LAG = 3
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  // Request and pin
  input  wire logic want_in,
  output var  logic pin_out
);
  // --------------------------------------------------------------------------
  // Pin follows the request after a lag, as a slow controller would
  // --------------------------------------------------------------------------
  int cnt;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_out <= 1'b0;
      cnt     <= 0;
    end else if (want_in == pin_out) begin
      cnt <= 0;
    end else if (cnt == LAG) begin
      pin_out <= want_in;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

`default_nettype wire

// file: sim/tb_converter_fault_sequencer.sv
`timescale 1ns/1ns
`default_nettype none

module tb_converter_fault_sequencer;
  localparam int FW  = 4;
  localparam int INI = 3;
  localparam int TON = 3;
  localparam logic [7:0] BAD = 8'h10;
  localparam fault_seq_pkg::sense_t OK_S = 11'h480;
  localparam fault_seq_pkg::sense_t FLT [4] = '{11'h280, 11'h520,
                                                11'h490, 11'h484};
  logic                  clk, arst_n, want, pin, trim_low, run, trim_act, irq;
  fault_seq_pkg::sense_t sense;
  logic                  awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready;
  logic [7:0]            awaddr, araddr;
  logic [31:0]           wdata, rdata, d;
  logic [3:0]            wstrb;
  logic [1:0]            bresp, rresp, r;
  int                    err_count, checked, cyc, n;

  converter_fault_sequencer #(.FAULT_WAIT_CYC(FW), .INIT_CYC(INI),
    .TURN_ON_CYC(TON), .IN_LOW_QUAL_CYC(2), .IN_HIGH_QUAL_CYC(2)) dut (
    .CLOCK_IN(clk), .ARST_N_IN(arst_n), .SENSE_IN(sense),
    .TURN_ON_PIN_IN(pin), .TRIM_PIN_LOW_IN(trim_low), .RUN_OUT(run),
    .TRIM_ACTIVE_OUT(trim_act), .IRQ_OUT(irq),
    .AWVALID_IN(awvalid), .AWREADY_OUT(awready), .AWADDR_IN(awaddr),
    .WVALID_IN(wvalid), .WREADY_OUT(wready), .WDATA_IN(wdata),
    .WSTRB_IN(wstrb), .BVALID_OUT(bvalid), .BREADY_IN(bready),
    .BRESP_OUT(bresp), .ARVALID_IN(arvalid), .ARREADY_OUT(arready),
    .ARADDR_IN(araddr), .RVALID_OUT(rvalid), .RREADY_IN(rready),
    .RDATA_OUT(rdata), .RRESP_OUT(rresp));

  turn_on_ctrl_model partner (.clk_in(clk), .arst_n_in(arst_n),
    .want_in(want), .pin_out(pin));

  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task automatic test_done();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Readies are looked at mid-cycle, where they are settled for the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= v;
    bready  <= 1'b1;
    do begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      r  = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do begin
      @(negedge clk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      d  = rdata;
      r  = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end while (!tr);
    rready <= 1'b0;
  endtask

  task automatic ev(input int b, input logic e);
    rd(fault_seq_pkg::EVENT_ADDR);
    check(d[b], e);
  endtask

  task automatic set(input fault_seq_pkg::sense_t s);
    @(posedge clk);
    sense <= s;
  endtask

  task automatic wait_run(input logic e);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (run !== e && n < 80);
  endtask

  // --------------------------------------------------------------------------
  // Stimulus
  // --------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end

  initial begin
    {arst_n, want, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, sense} = '0;
    wstrb    = 4'hf;
    trim_low = 1'b1;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    rd(fault_seq_pkg::CTRL_ADDR);
    check(d, fault_seq_pkg::CTRL_RESET);
    rd(fault_seq_pkg::MASK_ADDR);
    check(d, fault_seq_pkg::MASK_RESET);
    rd(BAD);
    check({r, d}, {fault_seq_pkg::RESP_SLVERR, 32'h0});
    wr(BAD, 32'h1);
    check(r, fault_seq_pkg::RESP_SLVERR);
    wr(fault_seq_pkg::CTRL_ADDR, 32'h1);
    want <= 1'b1;
    // Trim was captured already; later pin moves must not reach it
    trim_low <= 1'b0;
    repeat (20) @(posedge clk);
    check(run, 1'b0);
    set(OK_S);
    wait_run(1'b1);
    check(run, 1'b1);
    set(OK_S | 11'h020);
    @(negedge clk);
    check(run, 1'b0);
    set(OK_S);
    wait_run(1'b1);
    check(run, 1'b1);
    ev(fault_seq_pkg::EV_IN_HIGH, 1'b0);
    set(FLT[0]);
    set(OK_S);
    wait_run(1'b1);
    ev(fault_seq_pkg::EV_IN_LOW, 1'b0);
    for (int i = 0; i < 4; i++) begin
      set(FLT[i]);
      repeat (8) @(posedge clk);
      check(run, 1'b0);
      set(OK_S);
      wait_run(1'b1);
      check(run, 1'b1);
      if (i >= 2) check(n + 8 >= FW + INI + TON, 1'b1);
      if (i == 3) check(n > INI + TON, 1'b1);
      ev(i, 1'b1);
    end
    check(irq, 1'b0);
    wr(fault_seq_pkg::MASK_ADDR, 32'h0f);
    check(irq, 1'b1);
    wr(fault_seq_pkg::EVENT_ADDR, 32'h1f);
    check(irq, 1'b0);
    ev(fault_seq_pkg::EV_TEMP, 1'b0);
    for (int i = 2; i < 4; i++) begin
      set(FLT[i]);
      set(OK_S);
      wait_run(1'b1);
      check({run, n >= FW + INI + TON}, 2'b11);
    end
    wr(fault_seq_pkg::MASK_ADDR, 32'h10);
    for (int j = 0; j < 2; j++) begin
      set(OK_S | 11'h009);
      set(OK_S);
      repeat (30) @(posedge clk);
      check(run, 1'b0);
      check(irq, 1'b1);
      ev(fault_seq_pkg::EV_OUT_HIGH, 1'b1);
      rd(fault_seq_pkg::STATUS_ADDR);
      check({d[10], d[4]}, 2'b11);
      wr(fault_seq_pkg::EVENT_ADDR, 32'h10);
      check(irq, 1'b0);
      if (j == 0) begin
        want <= 1'b0;
        repeat (8) @(posedge clk);
        want <= 1'b1;
      end else begin
        set(OK_S | 11'h040);
        set(OK_S);
      end
      wait_run(1'b1);
      check(run, 1'b1);
    end
    wr(fault_seq_pkg::CTRL_ADDR, 32'h3);
    for (int k = 0; k < 2; k++) begin
      set(OK_S | 11'h003);
      set(OK_S | 11'h002);
      repeat (2) @(posedge clk);
      check(run, k[0]);
    end
    set(OK_S);
    check(trim_act, 1'b1);
    test_done();
  end
endmodule

`default_nettype wire
